/* design/drive_run_permit.sv */
`timescale 1ns/1ps
// Contract
// - Drive-enable input open blocks every run command and shows not-enabled.
// - Run held before drive-enable closes must be removed and reapplied first.
// - Drive-enable opening while running stops using the stop-method setting.
// - Serial-select input open uses terminals per reference setting, closed uses serial.
// - Inverted serial-select: open uses serial, closed uses terminals.
// - Command source changes only take effect while the motor is stopped (only the serial-select switch waits; source setting writes apply at once).
// - Hand-mode closed forces keypad speed source; open leaves reference setting.
// - Auto-mode open forces keypad speed; closed defers; run source unaffected.
// - Auto-mode and hand-mode both assigned raises the configuration conflict fault.
// - With bypass-enable, run whenever run command and bypass input both closed.
// - Bypass open with run asserted blocks running and shows not-enabled.
// - Bypass opening while running stops using the stop-method setting.
// - Two contact outputs with own selects; codes to 3B; defaults 0 and A.
// - Decode listed output codes; unlisted codes leave the output open.
// - During-run output closes with run command present and voltage output.
// - Zero-speed output closes while output frequency below minimum frequency.
// - Agree output closes while output frequency within agree width of command.
module drive_run_permit (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [31:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [31:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic [3:0]           contact_in,
	input  wire logic                 run_cmd_terminal,
	input  wire logic                 run_cmd_serial,
	input  wire logic                 run_cmd_keypad,
	input  wire logic                 overheat_reduced,
	input  wire logic                 output_active,
	input  wire logic                 motor_stopped,
	input  wire logic signed [15:0]   freq_out,
	input  wire logic signed [15:0]   freq_ref,
	input  wire logic [15:0]          aux_status,
	output logic                      run_permit,
	output logic                      stop_request,
	output logic [1:0]                stop_method,
	output logic                      not_enabled_indication,
	output logic                      config_conflict_fault,
	output logic                      run_from_serial,
	output logic                      speed_from_keypad,
	output logic [1:0]                contact_out,
	output logic                      irq
);

	// ****************************************
	// State
	// ****************************************
	localparam int NUM_OUT = 2;

	drive_permit_pkg::state_s st_ff;
	drive_permit_pkg::state_s nxt_st;
	drive_permit_pkg::func_s  fn;
	logic [drive_permit_pkg::NUM_IN-1:0] is_en;
	logic [drive_permit_pkg::NUM_IN-1:0] is_byp;
	logic [drive_permit_pkg::NUM_IN-1:0] is_ser;
	logic [drive_permit_pkg::NUM_IN-1:0] is_sern;
	logic [drive_permit_pkg::NUM_IN-1:0] is_auto;
	logic [drive_permit_pkg::NUM_IN-1:0] is_hand;
	logic [1:0]  ref_src;
	logic [1:0]  run_src;
	logic        run_cmd;
	logic [15:0] fout_abs;
	logic [15:0] fref_abs;
	logic [15:0] fdiff;
	logic [NUM_OUT-1:0] out_val;
	logic [drive_permit_pkg::NUM_IRQ-1:0] ev;
	logic [31:0] status_word;

	// ****************************************
	// Input function decode
	// ****************************************

	// Per-input comparison against the function codes
	generate
		for (genvar i = 0; i < drive_permit_pkg::NUM_IN; i++) begin : g_in
			logic [7:0] code;
			assign code       = st_ff.infunc[8*i +: 8];
			assign is_en[i]   = (code == drive_permit_pkg::IN_DRV_EN);
			assign is_byp[i]  = (code == drive_permit_pkg::IN_BYPASS);
			assign is_ser[i]  = (code == drive_permit_pkg::IN_SER);
			assign is_sern[i] = (code == drive_permit_pkg::IN_SER_N);
			assign is_auto[i] = (code == drive_permit_pkg::IN_AUTO);
			assign is_hand[i] = (code == drive_permit_pkg::IN_HAND);
		end
	endgenerate

	// Combine synchronised contacts with their functions
	always_comb begin
		fn.en_asg   = |is_en;
		fn.en_ok    = ((is_en & ~st_ff.in_s2) == '0);
		fn.byp_asg  = |is_byp;
		fn.byp_ok   = ((is_byp & ~st_ff.in_s2) == '0);
		fn.ser_req  = |(is_ser & st_ff.in_s2) | |(is_sern & ~st_ff.in_s2);
		fn.auto_asg = |is_auto;
		fn.hand_asg = |is_hand;
		fn.keypad   = |(is_hand & st_ff.in_s2) | |(is_auto & ~st_ff.in_s2);
	end

	// ****************************************
	// Command source selection
	// ****************************************

	// Latched serial selection overrides the settings
	always_comb begin
		ref_src = st_ff.ctrl[drive_permit_pkg::REF_LSB +: 2];
		run_src = st_ff.ctrl[drive_permit_pkg::RUN_LSB +: 2];
		if (st_ff.src_serial) begin
			ref_src = drive_permit_pkg::SRC_SERIAL;
			run_src = drive_permit_pkg::SRC_SERIAL;
		end
		case (run_src)
			drive_permit_pkg::SRC_KEYPAD:   run_cmd = run_cmd_keypad;
			drive_permit_pkg::SRC_TERMINAL: run_cmd = st_ff.run_s2;
			drive_permit_pkg::SRC_SERIAL:   run_cmd = run_cmd_serial;
			default:                        run_cmd = 1'b0;
		endcase
	end

	// Frequency magnitudes for direction-free compare
	always_comb begin
		fout_abs = freq_out[15] ? 16'(-freq_out) : 16'(freq_out);
		fref_abs = freq_ref[15] ? 16'(-freq_ref) : 16'(freq_ref);
		fdiff    = (fout_abs > fref_abs) ? fout_abs - fref_abs : fref_abs - fout_abs;
	end

	// ****************************************
	// Contact output decode
	// ****************************************

	// One selector per output
	generate
		for (genvar k = 0; k < NUM_OUT; k++) begin : g_out
			logic [7:0] sel;
			assign sel = st_ff.outsel[8*k +: 8];
			always_comb begin
				case (sel)
					drive_permit_pkg::OUT_RUN:     out_val[k] = run_cmd & output_active;
					drive_permit_pkg::OUT_ZERO:    out_val[k] = fout_abs < st_ff.minf[15:0];
					drive_permit_pkg::OUT_AGREE:   out_val[k] = fdiff <= st_ff.agree[15:0];
					8'h03: out_val[k] = aux_status[0];
					8'h04: out_val[k] = aux_status[1];
					8'h05: out_val[k] = aux_status[2];
					8'h06: out_val[k] = aux_status[3];
					8'h07: out_val[k] = aux_status[4];
					8'h08: out_val[k] = aux_status[5];
					drive_permit_pkg::OUT_OPT_REF: out_val[k] = st_ff.keypad;
					drive_permit_pkg::OUT_REMOTE:  out_val[k] = run_src == drive_permit_pkg::SRC_KEYPAD;
					8'h0b: out_val[k] = aux_status[6];
					8'h0c: out_val[k] = aux_status[7];
					8'h0d: out_val[k] = aux_status[8];
					8'h0e: out_val[k] = aux_status[9];
					drive_permit_pkg::OUT_UNUSED:  out_val[k] = 1'b0;
					8'h10: out_val[k] = aux_status[10];
					8'h11: out_val[k] = aux_status[11];
					8'h12: out_val[k] = aux_status[12];
					8'h17: out_val[k] = aux_status[13];
					8'h1a: out_val[k] = freq_out[15];
					8'h1e: out_val[k] = aux_status[14];
					8'h1f: out_val[k] = aux_status[15];
					8'h20: out_val[k] = st_ff.oh_s2;
					drive_permit_pkg::OUT_ENABLE:  out_val[k] = fn.en_ok & fn.byp_ok;
					drive_permit_pkg::OUT_WAIT:    out_val[k] = run_cmd & ~st_ff.run_permit;
					drive_permit_pkg::OUT_OH_RED:  out_val[k] = st_ff.oh_s2;
					drive_permit_pkg::OUT_SER_RUN: out_val[k] = run_src == drive_permit_pkg::SRC_SERIAL;
					default:                       out_val[k] = 1'b0;
				endcase
			end
		end
	endgenerate

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		nxt_st = st_ff;

		// Two-stage synchronisers on pins
		nxt_st.in_s1  = contact_in;
		nxt_st.in_s2  = st_ff.in_s1;
		nxt_st.run_s1 = run_cmd_terminal;
		nxt_st.run_s2 = st_ff.run_s1;
		nxt_st.oh_s1  = overheat_reduced;
		nxt_st.oh_s2  = st_ff.oh_s1;

		// Source switch only at standstill
		if (motor_stopped) begin
			nxt_st.src_serial = fn.ser_req;
		end

		// Run held across enable closing needs a cycle
		if (!run_cmd) begin
			nxt_st.need_cycle = 1'b0;
		end else if (fn.en_asg && !fn.en_ok) begin
			nxt_st.need_cycle = 1'b1;
		end

		nxt_st.conflict   = fn.auto_asg & fn.hand_asg;
		nxt_st.keypad     = fn.keypad | (ref_src == drive_permit_pkg::SRC_KEYPAD);
		nxt_st.run_permit = run_cmd & fn.en_ok & fn.byp_ok & ~nxt_st.need_cycle
			& ~nxt_st.conflict;
		nxt_st.stop_req   = output_active & (~fn.en_ok | ~fn.byp_ok);
		nxt_st.ne         = (fn.en_asg & ~fn.en_ok)
			| (fn.byp_asg & ~fn.byp_ok & run_cmd);
		nxt_st.cout       = out_val;
		nxt_st.prev_ne    = st_ff.ne;
		nxt_st.prev_conf  = st_ff.conflict;
		nxt_st.prev_stop  = st_ff.stop_req;

		// Write channel capture
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_st.aw_got = 1'b1;
			nxt_st.awaddr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end

		// Sticky events; set wins over clear
		if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = drive_permit_pkg::RESP_OKAY;
			case (st_ff.awaddr)
				drive_permit_pkg::CTRL_OFF:    nxt_st.ctrl   = merge(st_ff.ctrl);
				drive_permit_pkg::INFUNC_OFF:  nxt_st.infunc = merge(st_ff.infunc);
				drive_permit_pkg::OUTSEL_OFF:  nxt_st.outsel = merge(st_ff.outsel);
				drive_permit_pkg::MINF_OFF:    nxt_st.minf   = merge(st_ff.minf);
				drive_permit_pkg::AGREE_OFF:   nxt_st.agree  = merge(st_ff.agree);
				drive_permit_pkg::STATUS_OFF:  nxt_st.bresp  = drive_permit_pkg::RESP_OKAY;
				drive_permit_pkg::IRQ_ST_OFF: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.irq_st = st_ff.irq_st & ~st_ff.wdata[drive_permit_pkg::NUM_IRQ-1:0];
					end
				end
				drive_permit_pkg::IRQ_MSK_OFF: begin
					if (st_ff.wstrb[0]) begin
						nxt_st.irq_msk = st_ff.wdata[drive_permit_pkg::NUM_IRQ-1:0];
					end
				end
				default: nxt_st.bresp = drive_permit_pkg::RESP_SLVERR;
			endcase
		end
		nxt_st.irq_st = nxt_st.irq_st | ev;

		// Read channel
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp  = drive_permit_pkg::RESP_OKAY;
			case (s_axi_araddr[7:0])
				drive_permit_pkg::CTRL_OFF:    nxt_st.rdata = st_ff.ctrl;
				drive_permit_pkg::INFUNC_OFF:  nxt_st.rdata = st_ff.infunc;
				drive_permit_pkg::OUTSEL_OFF:  nxt_st.rdata = st_ff.outsel;
				drive_permit_pkg::MINF_OFF:    nxt_st.rdata = st_ff.minf;
				drive_permit_pkg::AGREE_OFF:   nxt_st.rdata = st_ff.agree;
				drive_permit_pkg::STATUS_OFF:  nxt_st.rdata = status_word;
				drive_permit_pkg::IRQ_ST_OFF:  nxt_st.rdata = 32'(st_ff.irq_st);
				drive_permit_pkg::IRQ_MSK_OFF: nxt_st.rdata = 32'(st_ff.irq_msk);
				default: begin
					nxt_st.rdata = 32'h0000_0000;
					nxt_st.rresp = drive_permit_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	// Byte-lane merge of a pending write
	function automatic logic [31:0] merge(input logic [31:0] old);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (st_ff.wstrb[b]) begin
				res[8*b +: 8] = st_ff.wdata[8*b +: 8];
			end
		end
		return res;
	endfunction : merge

	// Event rising edges; bit 3 is a level flag for a serial-select change held off while running
	always_comb begin
		ev[0] = st_ff.ne & ~st_ff.prev_ne;
		ev[1] = st_ff.conflict & ~st_ff.prev_conf;
		ev[2] = st_ff.stop_req & ~st_ff.prev_stop;
		ev[3] = ~motor_stopped & (fn.ser_req != st_ff.src_serial);
	end

	// Live status word
	always_comb begin
		status_word = {22'h00_0000, st_ff.cout, st_ff.keypad, st_ff.src_serial,
			st_ff.conflict, st_ff.ne, st_ff.need_cycle, st_ff.stop_req,
			st_ff.run_permit, motor_stopped};
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff        <= '0;
			st_ff.ctrl   <= drive_permit_pkg::CTRL_RST;
			st_ff.infunc <= drive_permit_pkg::INFUNC_RST;
			st_ff.outsel <= drive_permit_pkg::OUTSEL_RST;
			st_ff.minf   <= drive_permit_pkg::MINF_RST;
			st_ff.agree  <= drive_permit_pkg::AGREE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign s_axi_awready          = ~st_ff.aw_got & ~st_ff.bvalid;
	assign s_axi_wready           = ~st_ff.w_got & ~st_ff.bvalid;
	assign s_axi_bvalid           = st_ff.bvalid;
	assign s_axi_bresp            = st_ff.bresp;
	assign s_axi_arready          = ~st_ff.rvalid;
	assign s_axi_rvalid           = st_ff.rvalid;
	assign s_axi_rdata            = st_ff.rdata;
	assign s_axi_rresp            = st_ff.rresp;
	assign run_permit             = st_ff.run_permit;
	assign stop_request           = st_ff.stop_req;
	assign stop_method            = st_ff.ctrl[drive_permit_pkg::STOP_LSB +: 2];
	assign not_enabled_indication = st_ff.ne;
	assign config_conflict_fault  = st_ff.conflict;
	assign run_from_serial        = st_ff.src_serial;
	assign speed_from_keypad      = st_ff.keypad;
	assign contact_out            = st_ff.cout;
	assign irq                    = |(st_ff.irq_st & st_ff.irq_msk);

endmodule : drive_run_permit

/* shared/drive_permit_pkg.sv */
package drive_permit_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] CTRL_OFF    = 8'h00;
	localparam logic [7:0] INFUNC_OFF  = 8'h04;
	localparam logic [7:0] OUTSEL_OFF  = 8'h08;
	localparam logic [7:0] MINF_OFF    = 8'h0c;
	localparam logic [7:0] AGREE_OFF   = 8'h10;
	localparam logic [7:0] STATUS_OFF  = 8'h14;
	localparam logic [7:0] IRQ_ST_OFF  = 8'h18;
	localparam logic [7:0] IRQ_MSK_OFF = 8'h1c;

	// ****************************************
	// Reset values and field positions
	// ****************************************
	localparam logic [31:0] CTRL_RST   = 32'h0000_0001;
	localparam logic [31:0] INFUNC_RST = 32'h0000_0000;
	localparam logic [31:0] OUTSEL_RST = 32'h0000_0a00;
	localparam logic [31:0] MINF_RST   = 32'h0000_0000;
	localparam logic [31:0] AGREE_RST  = 32'h0000_0000;
	localparam int REF_LSB  = 0;
	localparam int RUN_LSB  = 2;
	localparam int STOP_LSB = 4;
	localparam int NUM_IN   = 4;
	localparam int NUM_IRQ  = 4;

	// ****************************************
	// Command sources
	// ****************************************
	localparam logic [1:0] SRC_KEYPAD   = 2'h0;
	localparam logic [1:0] SRC_TERMINAL = 2'h1;
	localparam logic [1:0] SRC_SERIAL   = 2'h2;

	// ****************************************
	// Input function codes
	// ****************************************
	localparam logic [7:0] IN_DRV_EN = 8'h6a;
	localparam logic [7:0] IN_SER    = 8'h6b;
	localparam logic [7:0] IN_SER_N  = 8'h6c;
	localparam logic [7:0] IN_AUTO   = 8'h6d;
	localparam logic [7:0] IN_HAND   = 8'h6e;
	localparam logic [7:0] IN_BYPASS = 8'h70;

	// ****************************************
	// Output function codes
	// ****************************************
	localparam logic [7:0] OUT_RUN     = 8'h00;
	localparam logic [7:0] OUT_ZERO    = 8'h01;
	localparam logic [7:0] OUT_AGREE   = 8'h02;
	localparam logic [7:0] OUT_OPT_REF = 8'h09;
	localparam logic [7:0] OUT_REMOTE  = 8'h0a;
	localparam logic [7:0] OUT_UNUSED  = 8'h0f;
	localparam logic [7:0] OUT_ENABLE  = 8'h38;
	localparam logic [7:0] OUT_WAIT    = 8'h39;
	localparam logic [7:0] OUT_OH_RED  = 8'h3a;
	localparam logic [7:0] OUT_SER_RUN = 8'h3b;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Decoded contact functions
	typedef struct packed {
		logic en_asg;
		logic en_ok;
		logic byp_asg;
		logic byp_ok;
		logic ser_req;
		logic auto_asg;
		logic hand_asg;
		logic keypad;
	} func_s;

	// Whole block state
	typedef struct packed {
		logic [NUM_IN-1:0] in_s1;
		logic [NUM_IN-1:0] in_s2;
		logic              run_s1;
		logic              run_s2;
		logic              oh_s1;
		logic              oh_s2;
		logic [31:0]       ctrl;
		logic [31:0]       infunc;
		logic [31:0]       outsel;
		logic [31:0]       minf;
		logic [31:0]       agree;
		logic [NUM_IRQ-1:0] irq_st;
		logic [NUM_IRQ-1:0] irq_msk;
		logic              src_serial;
		logic              need_cycle;
		logic              prev_ne;
		logic              prev_conf;
		logic              prev_stop;
		logic              run_permit;
		logic              stop_req;
		logic              ne;
		logic              conflict;
		logic              keypad;
		logic [1:0]        cout;
		logic              aw_got;
		logic              w_got;
		logic [7:0]        awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} state_s;

endpackage : drive_permit_pkg

/* verification/drive_far_side.sv */
`timescale 1ns/1ps
// ****
// Motor and power stage model
// ****
module drive_far_side #(
	parameter int DECEL = 40
) (
	input  wire logic aclk,
	input  wire logic run_permit,
	input  wire logic hold_run,
	output logic      output_active,
	output logic      motor_stopped
);
	int ramp_ff = 0;

	// Voltage stays on while the motor ramps down
	always_ff @(posedge aclk) begin
		if (run_permit)
			ramp_ff <= DECEL;
		else if (ramp_ff > 0)
			ramp_ff <= ramp_ff - 1;
	end
	assign output_active = run_permit || hold_run || (ramp_ff > 0);
	assign motor_stopped = !output_active;
endmodule : drive_far_side

/* verification/drive_permit_sva.sv */
`timescale 1ns/1ps
// ****
// Permit and bus checker
// ****
module drive_permit_sva (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        run_cmd_terminal,
	input wire logic        run_cmd_serial,
	input wire logic        run_cmd_keypad,
	input wire logic        run_permit,
	input wire logic        stop_request,
	input wire logic        not_enabled_indication,
	input wire logic        config_conflict_fault,
	input wire logic        irq
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Every stop cause withholds the permit
	fault_block_a: assert property (config_conflict_fault |-> !run_permit)
		else $error("permit during conflict fault");
	ne_block_a: assert property (not_enabled_indication |-> !run_permit)
		else $error("permit while not enabled");
	stop_block_a: assert property (stop_request |-> !run_permit)
		else $error("permit while stopping");
	no_cmd_a: assert property (
		(!run_cmd_terminal && !run_cmd_serial && !run_cmd_keypad)[*4] |-> !run_permit)
		else $error("permit without any run command");

	// Bus answers held and timely
	bhold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	rhold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	rlat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	wlat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");

	// Outputs quiet after a reset edge
	rst_quiet_a: assert property (disable iff (1'b0)
		!aresetn |=> !run_permit && !irq && !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs active after reset");
endmodule : drive_permit_sva

bind drive_run_permit drive_permit_sva drive_permit_sva_i (.aclk, .aresetn, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .run_cmd_terminal,
	.run_cmd_serial, .run_cmd_keypad, .run_permit, .stop_request, .not_enabled_indication,
	.config_conflict_fault, .irq);

/* verification/drive_run_permit_bench.sv */
`timescale 1ns/1ps
// ****
// Run permit bench
// ****
module drive_run_permit_bench;
	logic        aclk, aresetn, hold_run, irq;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, contact_in;
	logic [1:0]  s_axi_bresp, s_axi_rresp, stop_method, contact_out;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        run_cmd_terminal, run_cmd_serial, run_cmd_keypad, overheat_reduced;
	logic        output_active, motor_stopped, run_permit, stop_request, run_from_serial;
	logic        not_enabled_indication, config_conflict_fault, speed_from_keypad;
	logic signed [15:0] freq_out, freq_ref;
	logic [15:0] aux_status;
	logic [65:0] rq[$];
	logic [1:0]  bq[$];
	int          n_mismatch, n_tests, seed, f, g;
	logic [8:0]  codes [4];

	drive_run_permit drive_run_permit_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .contact_in, .run_cmd_terminal,
		.run_cmd_serial, .run_cmd_keypad, .overheat_reduced, .output_active, .motor_stopped,
		.freq_out, .freq_ref, .aux_status, .run_permit, .stop_request, .stop_method,
		.not_enabled_indication, .config_conflict_fault, .run_from_serial, .speed_from_keypad,
		.contact_out, .irq);
	drive_far_side #(.DECEL(40)) drive_far_side_i (.aclk, .run_permit, .hold_run,
		.output_active, .motor_stopped);

	// Clock
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Inputs settle through the synchronisers
	task automatic settle;
		@(posedge aclk);
		{overheat_reduced, aux_status} <= 17'($random(seed));
		repeat (8) @(posedge aclk);
	endtask : settle

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = drive_permit_pkg::RESP_OKAY);
		bq.push_back(r);
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {24'h0, a, d, 4'hf};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1,
		input logic [1:0] r = drive_permit_pkg::RESP_OKAY);
		rq.push_back({r, e, m});
		@(posedge aclk);
		s_axi_araddr <= {24'h0, a};
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd

	// Status fields after the inputs settle
	task automatic st(input logic [31:0] m, input logic [31:0] e);
		settle;
		rd(drive_permit_pkg::STATUS_OFF, e, m);
	endtask : st

	// Scoreboard takes the oldest note at each answer
	always @(negedge aclk) begin : mon
		logic [65:0] n;
		if (s_axi_rvalid && s_axi_rready) begin
			n = rq.pop_front();
			chk({s_axi_rresp, s_axi_rdata & n[31:0]}, {n[65:64], n[63:32] & n[31:0]});
		end
		if (s_axi_bvalid && s_axi_bready)
			chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
	end

	function automatic int ab(input int v);
		return (v < 0) ? -v : v;
	endfunction : ab

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude

	// Watchdog
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		conclude;
	end

	// Main sequence
	initial begin
		seed = 32'h146d4ead;
		{aresetn, hold_run, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
		{contact_in, run_cmd_terminal, run_cmd_serial, run_cmd_keypad, overheat_reduced} = '0;
		{freq_out, freq_ref, aux_status} = '0;
		codes = '{{drive_permit_pkg::OUT_UNUSED, 1'b0}, {8'h13, 1'b0},
			{drive_permit_pkg::OUT_ENABLE, 1'b1}, {drive_permit_pkg::OUT_REMOTE, 1'b0}};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rd(drive_permit_pkg::CTRL_OFF, drive_permit_pkg::CTRL_RST);
		rd(drive_permit_pkg::OUTSEL_OFF, drive_permit_pkg::OUTSEL_RST);
		rd(8'h40, 32'h0, '1, drive_permit_pkg::RESP_SLVERR);
		wr(8'h40, 32'h1, drive_permit_pkg::RESP_SLVERR);
		chk({32'h0, contact_out}, 34'h2);
		// Drive enable on input 0, terminal run, stop method 2
		wr(drive_permit_pkg::CTRL_OFF, 32'h25);
		wr(drive_permit_pkg::IRQ_MSK_OFF, 32'h1);
		wr(drive_permit_pkg::INFUNC_OFF, {24'h0, drive_permit_pkg::IN_DRV_EN});
		run_cmd_terminal <= 1'b1;
		st(32'h12, 32'h10);
		chk({33'h0, irq}, 34'h1);
		wr(drive_permit_pkg::IRQ_ST_OFF, 32'h1);
		@(negedge aclk);
		chk({33'h0, irq}, 34'h0);
		contact_in <= 4'h1;
		st(32'h0a, 32'h08);
		run_cmd_terminal <= 1'b0;
		settle;
		run_cmd_terminal <= 1'b1;
		st(32'h106, 32'h102);
		contact_in <= 4'h0;
		st(32'h06, 32'h04);
		chk({32'h0, stop_method}, 34'h2);
		run_cmd_terminal <= 1'b0;
		repeat (60) @(posedge aclk);
		// Bypass enable needs no cycling of the run command
		wr(drive_permit_pkg::INFUNC_OFF, {24'h0, drive_permit_pkg::IN_BYPASS});
		run_cmd_terminal <= 1'b1;
		st(32'h12, 32'h10);
		contact_in <= 4'h1;
		st(32'h02, 32'h02);
		contact_in <= 4'h0;
		st(32'h06, 32'h04);
		run_cmd_terminal <= 1'b0;
		repeat (60) @(posedge aclk);
		// Serial source select, changed only while stopped
		wr(drive_permit_pkg::INFUNC_OFF, {16'h0, drive_permit_pkg::IN_SER, 8'h0});
		contact_in <= 4'h2;
		st(32'h40, 32'h40);
		chk({33'h0, run_from_serial}, 34'h1);
		contact_in <= 4'h0;
		st(32'h40, 32'h0);
		hold_run <= 1'b1;
		contact_in <= 4'h2;
		st(32'h40, 32'h0);
		rd(drive_permit_pkg::IRQ_ST_OFF, 32'h8, 32'h8);
		hold_run <= 1'b0;
		st(32'h40, 32'h40);
		wr(drive_permit_pkg::INFUNC_OFF, {16'h0, drive_permit_pkg::IN_SER_N, 8'h0});
		st(32'h40, 32'h0);
		contact_in <= 4'h0;
		st(32'h40, 32'h40);
		// Hand and auto speed source on input 2
		for (int i = 0; i < 4; i++) begin
			wr(drive_permit_pkg::INFUNC_OFF,
				{8'h0, (i < 2) ? drive_permit_pkg::IN_HAND : drive_permit_pkg::IN_AUTO, 16'h0});
			contact_in <= {1'b0, i[0], 2'h0};
			st(32'h80, {24'h0, i[0] ^ i[1], 7'h0});
		end
		wr(drive_permit_pkg::INFUNC_OFF,
			{8'h0, drive_permit_pkg::IN_HAND, drive_permit_pkg::IN_AUTO, 8'h0});
		st(32'h20, 32'h20);
		chk({33'h0, config_conflict_fault}, 34'h1);
		// Zero speed and agree outputs with random frequencies
		wr(drive_permit_pkg::INFUNC_OFF, 32'h0);
		wr(drive_permit_pkg::MINF_OFF, 32'h64);
		wr(drive_permit_pkg::AGREE_OFF, 32'ha);
		wr(drive_permit_pkg::OUTSEL_OFF,
			{16'h0, drive_permit_pkg::OUT_AGREE, drive_permit_pkg::OUT_ZERO});
		for (int i = 0; i < 8; i++) begin
			@(posedge aclk);
			f = $random(seed) % 200;
			g = (i[0] ? -f : f) + $random(seed) % 13;
			freq_out <= f[15:0];
			freq_ref <= g[15:0];
			settle;
			@(negedge aclk);
			chk({32'h0, contact_out}, {32'h0, ab(ab(f) - ab(g)) <= 10, ab(f) < 100});
		end
		// Listed, unused and unassigned codes on both outputs
		for (int i = 0; i < 4; i++) begin
			wr(drive_permit_pkg::OUTSEL_OFF, {16'h0, codes[i][8:1], codes[i][8:1]});
			settle;
			@(negedge aclk);
			chk({32'h0, contact_out}, {32'h0, {2{codes[i][0]}}});
		end
		wr(drive_permit_pkg::IRQ_MSK_OFF, 32'h0);
		@(negedge aclk);
		chk({33'h0, irq}, 34'h0);
		conclude;
	end
endmodule : drive_run_permit_bench
